// [hdl/pps_pkg.sv]
package pps_pkg;
	// ==========================================
	// timing
	localparam int CLK_MHZ = 10;
	// byte_proc_time and cmd_proc_time, in microseconds
	localparam int BYTE_PROC_US = 20;
	localparam int CMD_PROC_US = 40;
	localparam int BYTE_CYC = BYTE_PROC_US * CLK_MHZ;
	localparam int CMD_CYC = CMD_PROC_US * CLK_MHZ;
	// chain_window, kept by the host only
	localparam int CHAIN_WINDOW_MS = 10;
	// ==========================================
	// register map
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CFG = 12'h008;
	// ==========================================
	// command codes
	localparam logic [3:0] OP_SELECT = 4'h3;
	localparam logic [3:0] OP_LAUNCH = 4'h4;
	localparam logic [3:0] OP_PRESET = 4'h5;
	localparam logic [3:0] OP_HALT = 4'h6;
	localparam logic [3:0] OP_SILENCE = 4'h7;
	localparam logic [3:0] OP_REP_SET = 4'h8;
	localparam logic [3:0] OP_REP_CLR = 4'h9;
	localparam logic [7:0] OP_AMP_MODE = 8'h04;
	localparam logic [7:0] OP_GAIN = 8'h08;
	localparam logic [7:0] OP_WIDE_SELECT = 8'hC4;
	localparam logic [7:0] OP_WIDE_LAUNCH = 8'hC8;
	// ==========================================
	// values after reset and fixed counts
	localparam logic [3:0] GAIN_0DB = 4'h0;
	localparam logic [3:0] GAIN_RST = 4'h0;
	localparam logic [15:0] FADE_TICKS = 16'h0020;
	localparam logic [15:0] SIL_UNIT = 16'h0008;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BYTE = 3'b001,
		ST_NEXT = 3'b010,
		ST_CMD = 3'b011,
		ST_EXEC = 3'b100,
		ST_FETCH = 3'b101
	} pps_state_e;
endpackage

// [hdl/pps_sequencer.sv]
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module pps_sequencer import pps_pkg::*; (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [31:0] PRDATA,
	// sample clock pin, one tick per output sample
	input wire logic PCM_CLK,
	// flash address lookup
	output logic FLASH_REQ,
	output logic [11:0] FLASH_ADDR,
	input wire logic FLASH_ACK,
	input wire logic [15:0] FLASH_LEN,
	// status
	output logic COMMAND_BUSY_N,
	output logic [3:0] NEXT_CMD_READY,
	output logic [3:0] CHANNEL_PLAYING_N,
	output logic [3:0] SPK_GAIN
);

	function automatic logic [1:0] low_ch(input logic [3:0] m);
		low_ch = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
	endfunction

	// ==========================================
	// sample clock synchroniser
	logic [2:0] pcm_ff, nxt_pcm;
	logic tick;

	always_comb begin
		nxt_pcm = {pcm_ff[1:0], PCM_CLK};
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pcm_ff <= 3'h0;
		end else begin
			pcm_ff <= nxt_pcm;
		end
	end

	assign tick = pcm_ff[1] & ~pcm_ff[2];

	// ==========================================
	// apb slave
	logic [31:0] prdata_ff, nxt_prdata;
	logic err_ff, nxt_err;
	logic wr_cmd;
	logic st_idle_or_next;
	logic fad_ff, class_d_select_ff;
	logic [3:0] gain_ff, rep_v, qv_v;
	logic [3:0] busy_v, ncr_v;

	assign PREADY = 1'b1;
	assign PRDATA = prdata_ff;
	assign PSLVERR = err_ff;
	// writes while busy are dropped
	assign wr_cmd = PSEL & PENABLE & PWRITE & (PADDR == OFS_CMD)
		& st_idle_or_next;

	always_comb begin
		nxt_prdata = prdata_ff;
		nxt_err = err_ff;
		if (PSEL & ~PENABLE) begin
			nxt_err = 1'b0;
			case (PADDR)
				OFS_CMD: nxt_prdata = 32'h0;
				OFS_STAT: nxt_prdata = {16'h0, rep_v, 3'h0,
					st_idle_or_next, ~busy_v, ncr_v};
				OFS_CFG: nxt_prdata = {24'h0, 2'h0, fad_ff, class_d_select_ff,
					gain_ff};
				default: begin
					nxt_prdata = 32'h0;
					nxt_err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_ff <= 32'h0;
			err_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			err_ff <= nxt_err;
		end
	end

	// ==========================================
	// command interpreter
	pps_state_e st_ff, nxt_st;
	logic [11:0] cnt_ff, nxt_cnt;
	logic [7:0] op_ff, nxt_op;
	logic [15:0] bytes_ff, nxt_bytes;
	logic [1:0] left_ff, nxt_left;
	logic [3:0] mask_ff, nxt_mask;
	logic [11:0] sel_ff [4];
	logic [11:0] nxt_sel [4];
	logic [11:0] addr_ff, nxt_addr;
	logic nxt_fad, nxt_class_d_select;
	logic [3:0] nxt_gain, gout_ff, nxt_gout;
	logic [3:0] prep, go, halt, rset, rclr;
	logic [15:0] go_len;
	logic [1:0] c;

	assign st_idle_or_next = (st_ff == ST_IDLE) | (st_ff == ST_NEXT);
	assign COMMAND_BUSY_N = st_idle_or_next;
	assign FLASH_REQ = (st_ff == ST_FETCH);
	assign FLASH_ADDR = addr_ff;
	assign SPK_GAIN = gout_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_op = op_ff;
		nxt_bytes = bytes_ff;
		nxt_left = left_ff;
		nxt_mask = mask_ff;
		nxt_sel = sel_ff;
		nxt_fad = fad_ff;
		nxt_class_d_select = class_d_select_ff;
		nxt_gain = gain_ff;
		prep = 4'h0;
		go = 4'h0;
		halt = 4'h0;
		rset = 4'h0;
		rclr = 4'h0;
		go_len = FLASH_LEN;
		c = 2'd0;
		case (st_ff)
			ST_IDLE: if (wr_cmd) begin
				nxt_op = PWDATA[7:0];
				if (PWDATA[7:4] inside {OP_PRESET, OP_HALT, OP_REP_SET,
					OP_REP_CLR}) begin
					nxt_left = 2'd0;
					nxt_st = ST_CMD;
					nxt_cnt = 12'(CMD_CYC - 1);
				end else begin
					nxt_left = (PWDATA[7:0] == OP_WIDE_LAUNCH ||
						PWDATA[7:0] == OP_WIDE_SELECT) ? 2'd2 : 2'd1;
					nxt_st = ST_BYTE;
					nxt_cnt = 12'(BYTE_CYC - 1);
				end
			end
			ST_BYTE: begin
				// next byte only after byte_proc_time
				nxt_cnt = cnt_ff - 12'h001;
				if (cnt_ff == 12'h000) begin
					nxt_st = ST_NEXT;
				end
			end
			ST_NEXT: if (wr_cmd) begin
				nxt_bytes = {bytes_ff[7:0], PWDATA[7:0]};
				nxt_left = left_ff - 2'd1;
				if (left_ff == 2'd1) begin
					nxt_st = ST_CMD;
					nxt_cnt = 12'(CMD_CYC - 1);
				end else begin
					nxt_st = ST_BYTE;
					nxt_cnt = 12'(BYTE_CYC - 1);
				end
			end
			ST_CMD: begin
				// cmd_proc_time before acting
				nxt_cnt = cnt_ff - 12'h001;
				if (cnt_ff == 12'h000) begin
					nxt_st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				nxt_st = ST_IDLE;
				if (op_ff[7:4] == OP_LAUNCH || op_ff == OP_WIDE_LAUNCH) begin
					c = (op_ff == OP_WIDE_LAUNCH) ? bytes_ff[13:12]
						: op_ff[1:0];
					nxt_sel[c] = (op_ff == OP_WIDE_LAUNCH) ? bytes_ff[11:0]
						: {2'b00, op_ff[3:2], bytes_ff[7:0]};
					if (ncr_v[c]) begin
						prep[c] = 1'b1;
						nxt_mask = 4'h1 << c;
						nxt_st = ST_FETCH;
					end
				end else if (op_ff[7:4] == OP_PRESET) begin
					prep = op_ff[3:0] & ncr_v;
					nxt_mask = op_ff[3:0] & ncr_v;
					if ((op_ff[3:0] & ncr_v) != 4'h0) begin
						nxt_st = ST_FETCH;
					end
				end else if (op_ff[7:4] == OP_SILENCE) begin
					// silence length from second byte
					prep = op_ff[3:0] & ~qv_v;
					go = op_ff[3:0] & ~qv_v;
					go_len = ({8'h00, bytes_ff[7:0]} + 16'h0001) * SIL_UNIT;
				end else if (op_ff[7:4] == OP_HALT) begin
					halt = op_ff[3:0];
				end else if (op_ff[7:4] == OP_REP_SET) begin
					rset = op_ff[3:0];
				end else if (op_ff[7:4] == OP_REP_CLR) begin
					rclr = op_ff[3:0];
				end else if (op_ff[7:4] == OP_SELECT) begin
					nxt_sel[op_ff[1:0]] = {2'b00, op_ff[3:2], bytes_ff[7:0]};
				end else if (op_ff == OP_WIDE_SELECT) begin
					nxt_sel[bytes_ff[13:12]] = bytes_ff[11:0];
				end else if (op_ff[7:2] == OP_AMP_MODE[7:2]) begin
					// bit 1 of the first byte selects class D; bit 7 of the second byte enables fade
					nxt_class_d_select = op_ff[1];
					nxt_fad = bytes_ff[7];
				end else if (op_ff == OP_GAIN) begin
					nxt_gain = bytes_ff[5:2];
				end
			end
			ST_FETCH: if (FLASH_ACK) begin
				// masked channels fetched lowest first
				c = low_ch(mask_ff);
				go[c] = 1'b1;
				nxt_mask = mask_ff & ~(4'h1 << c);
				if (nxt_mask == 4'h0) begin
					nxt_st = ST_IDLE;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
		nxt_addr = nxt_sel[low_ch(nxt_mask)];
		// class D ignores the gain setting
		nxt_gout = nxt_class_d_select ? GAIN_0DB : nxt_gain;
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_ff <= ST_IDLE;
			cnt_ff <= 12'h000;
			op_ff <= 8'h00;
			bytes_ff <= 16'h0000;
			left_ff <= 2'd0;
			mask_ff <= 4'h0;
			sel_ff <= '{default: 12'h000};
			addr_ff <= 12'h000;
			fad_ff <= 1'b0;
			class_d_select_ff <= 1'b0;
			gain_ff <= GAIN_RST;
			gout_ff <= GAIN_RST;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			op_ff <= nxt_op;
			bytes_ff <= nxt_bytes;
			left_ff <= nxt_left;
			mask_ff <= nxt_mask;
			sel_ff <= nxt_sel;
			addr_ff <= nxt_addr;
			fad_ff <= nxt_fad;
			class_d_select_ff <= nxt_class_d_select;
			gain_ff <= nxt_gain;
			gout_ff <= nxt_gout;
		end
	end

	// ==========================================
	// playback channels, one state set each
	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic run_ff, busy_ff, ncr_ff, rep_ff, qv_ff, pend_ff, fade_ff;
		logic nxt_run, nxt_busy, nxt_ncr, nxt_rep, nxt_qv, nxt_pend;
		logic nxt_fade;
		logic [15:0] cnt_ff, len_ff, qlen_ff;
		logic [15:0] nxt_cnt, nxt_len, nxt_qlen;

		assign busy_v[i] = busy_ff;
		assign ncr_v[i] = ncr_ff;
		assign rep_v[i] = rep_ff;
		assign qv_v[i] = qv_ff;
		assign NEXT_CMD_READY[i] = ncr_ff;
		assign CHANNEL_PLAYING_N[i] = ~busy_ff;

		always_comb begin
			nxt_run = run_ff;
			nxt_busy = busy_ff;
			nxt_ncr = ncr_ff;
			nxt_rep = rep_ff;
			nxt_qv = qv_ff;
			nxt_pend = pend_ff;
			nxt_fade = fade_ff;
			nxt_cnt = cnt_ff;
			nxt_len = len_ff;
			nxt_qlen = qlen_ff;
			if (tick & run_ff & (cnt_ff <= 16'h0001)) begin
				if (fade_ff) begin
					nxt_run = 1'b0;
					nxt_busy = 1'b0;
					nxt_fade = 1'b0;
					nxt_ncr = 1'b1;
				end else if (rep_ff) begin
					nxt_cnt = len_ff;
				end else if (qv_ff) begin
					nxt_cnt = qlen_ff; // no gap
					nxt_len = qlen_ff;
					nxt_qv = 1'b0;
					nxt_ncr = 1'b1;
				end else begin
					nxt_run = 1'b0;
					nxt_busy = pend_ff;
					nxt_ncr = ~pend_ff;
				end
			end else if (tick & run_ff) begin
				nxt_cnt = cnt_ff - 16'h0001;
			end
			if (prep[i]) begin
				nxt_busy = 1'b1;
				nxt_ncr = 1'b0;
				nxt_pend = 1'b1;
			end
			if (go[i]) begin
				nxt_pend = 1'b0;
				if (nxt_run) begin
					nxt_qv = 1'b1; // held ready low
					nxt_qlen = go_len;
				end else begin
					nxt_run = 1'b1;
					nxt_cnt = go_len;
					nxt_len = go_len;
					nxt_ncr = ~rep_ff;
				end
			end
			if (rset[i] & run_ff) begin
				nxt_rep = 1'b1;
				nxt_ncr = 1'b0;
			end
			if (rclr[i] & rep_ff) begin
				nxt_rep = 1'b0;
				nxt_ncr = ~nxt_qv & ~nxt_pend;
			end
			if (halt[i]) begin
				nxt_rep = 1'b0;
				nxt_qv = 1'b0;
				nxt_pend = 1'b0;
				if (fad_ff & run_ff) begin
					nxt_fade = 1'b1;
					nxt_cnt = FADE_TICKS;
				end else begin
					nxt_run = 1'b0;
					nxt_busy = 1'b0;
					nxt_ncr = 1'b1;
					nxt_fade = 1'b0;
				end
			end
		end

		always_ff @(posedge REF_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				run_ff <= 1'b0;
				busy_ff <= 1'b0;
				ncr_ff <= 1'b1;
				rep_ff <= 1'b0;
				qv_ff <= 1'b0;
				pend_ff <= 1'b0;
				fade_ff <= 1'b0;
				cnt_ff <= 16'h0000;
				len_ff <= 16'h0000;
				qlen_ff <= 16'h0000;
			end else begin
				run_ff <= nxt_run;
				busy_ff <= nxt_busy;
				ncr_ff <= nxt_ncr;
				rep_ff <= nxt_rep;
				qv_ff <= nxt_qv;
				pend_ff <= nxt_pend;
				fade_ff <= nxt_fade;
				cnt_ff <= nxt_cnt;
				len_ff <= nxt_len;
				qlen_ff <= nxt_qlen;
			end
		end
	end

endmodule // pps_sequencer

// [tb/pps_flash_model.sv]
`timescale 1ns/1ps
module pps_flash_model import pps_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// lookup
	input wire logic req,
	input wire logic [11:0] addr,
	output logic ack,
	output logic [15:0] len,
	// answer delay in cycles
	input wire logic [31:0] dly
);
	// ==========
	// lookup answer
	int cnt_ff;
	int nxt_cnt;
	logic ack_ff;
	logic nxt_ack;
	always_comb begin
		nxt_ack = req && !ack_ff && cnt_ff >= dly;
		nxt_cnt = (req && !nxt_ack) ? cnt_ff + 1 : 0;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 0;
			ack_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			ack_ff <= nxt_ack;
		end
	end
	assign ack = ack_ff;
	// length is the phrase number; garbage off the ack catches late samples
	assign len = ack_ff ? {4'h0, addr} : ~{4'h0, addr};
endmodule // pps_flash_model

// [tb/pps_seq_monitor.sv]
`timescale 1ns/1ps
module pps_seq_monitor import pps_pkg::*; (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PSLVERR,
	// flash and status
	input wire logic FLASH_REQ,
	input wire logic FLASH_ACK,
	input wire logic COMMAND_BUSY_N,
	input wire logic [3:0] NEXT_CMD_READY,
	input wire logic [3:0] CHANNEL_PLAYING_N,
	input wire logic [3:0] SPK_GAIN
);
	// ==========
	// busy low length
	logic [15:0] lo_ff;
	logic [15:0] nxt_lo;
	logic acc;
	assign acc = PSEL && PENABLE;
	always_comb begin
		nxt_lo = COMMAND_BUSY_N ? 16'h0000 : lo_ff + 16'h0001;
	end
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lo_ff <= 16'h0000;
		end else begin
			lo_ff <= nxt_lo;
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	// ==========
	// checks
	byte_take_a: assert property (
		acc && PWRITE && PADDR == OFS_CMD && COMMAND_BUSY_N |=> !COMMAND_BUSY_N)
		else $error("busy not dropped after byte");
	byte_wait_a: assert property (
		$rose(COMMAND_BUSY_N) |-> lo_ff >= BYTE_CYC)
		else $error("next byte allowed too early");
	fetch_wait_a: assert property (
		$rose(FLASH_REQ) |-> lo_ff >= CMD_CYC)
		else $error("fetch before command time");
	fetch_busy_a: assert property (
		FLASH_REQ |-> !COMMAND_BUSY_N)
		else $error("busy released during fetch");
	ack_release_a: assert property (
		FLASH_ACK |=> COMMAND_BUSY_N && !FLASH_REQ)
		else $error("busy not released after ack");
	idle_ready_a: assert property (
		(CHANNEL_PLAYING_N & ~NEXT_CMD_READY) == 4'h0)
		else $error("idle channel not ready");
	ready_drop_a: assert property (
		(~NEXT_CMD_READY & $past(NEXT_CMD_READY)) != 4'h0
		|-> !$past(COMMAND_BUSY_N))
		else $error("ready dropped with no command");
	gain_d_a: assert property (
		acc && !PWRITE && PADDR == OFS_CFG && PRDATA[4] |-> SPK_GAIN == GAIN_0DB)
		else $error("class d gain not 0 dB");
	gain_ab_a: assert property (
		acc && !PWRITE && PADDR == OFS_CFG && !PRDATA[4] |-> SPK_GAIN == PRDATA[3:0])
		else $error("class ab gain not applied");
	unmapped_a: assert property (
		acc && PADDR > OFS_CFG |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not flagged");
	cover property (FLASH_ACK);
	cover property ($rose(CHANNEL_PLAYING_N[0]));
	cover property (acc && PSLVERR);
endmodule // pps_seq_monitor
bind pps_sequencer pps_seq_monitor u_pps_seq_monitor (.REF_CLK, .ARST_N,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PSLVERR, .FLASH_REQ,
	.FLASH_ACK, .COMMAND_BUSY_N, .NEXT_CMD_READY, .CHANNEL_PLAYING_N,
	.SPK_GAIN);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb import pps_pkg::*;;
	// ==========
	// signals
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic pcm_clk = 1'b0;
	logic pready, pslverr, f_req, f_ack, busy_n, e;
	logic [31:0] prdata, q;
	logic [11:0] f_addr;
	logic [15:0] f_len;
	logic [3:0] ready, phrase_launch_cmd_n, gain;
	int dly = 0;
	int errors = 0;
	int cmp_count = 0;
	int nf = 0;
	int nr0 = 0;
	int t_imm = 0;
	int w, r, fb;
	always #50 ref_clk = ~ref_clk;
	always #400 pcm_clk = ~pcm_clk;
	always @(posedge ref_clk) begin
		if (f_ack === 1'b1) nf++;
	end
	always @(posedge phrase_launch_cmd_n[0]) nr0++;
	pps_sequencer u_pps_sequencer (.REF_CLK(ref_clk), .ARST_N(arst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
		.PRDATA(prdata), .PCM_CLK(pcm_clk), .FLASH_REQ(f_req),
		.FLASH_ADDR(f_addr), .FLASH_ACK(f_ack), .FLASH_LEN(f_len),
		.COMMAND_BUSY_N(busy_n), .NEXT_CMD_READY(ready),
		.CHANNEL_PLAYING_N(phrase_launch_cmd_n), .SPK_GAIN(gain));
	pps_flash_model u_pps_flash_model (.ref_clk(ref_clk), .arst_n(arst_n),
		.req(f_req), .addr(f_addr), .ack(f_ack), .len(f_len), .dly(dly));
	// ==========
	// helpers
	task chk(input logic [63:0] g, input logic [63:0] x);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			errors++;
			$display("Error %0t: no pready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic sig(input int k, input int c);
		case (k)
			0: return phrase_launch_cmd_n[c];
			1: return ready[c];
			2: return busy_n;
			default: return f_req;
		endcase
	endfunction
	task wfor(input int k, input int c, output int n);
		n = 0;
		while (sig(k, c) !== 1'b1 && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			$display("Error %0t: wait timed out", $time);
		end
	endtask
	task cmd(input logic [7:0] b);
		wfor(2, 0, w);
		apb(1'b1, OFS_CMD, {24'h0, b});
		@(posedge ref_clk);
	endtask
	task launch(input logic [7:0] b0, input logic [7:0] b1);
		cmd(b0);
		cmd(b1);
	endtask
	// ==========
	// scenarios
	task t_regs;
		apb(1'b0, OFS_STAT, 32'h0);
		chk(q, 32'h000001FF);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({e, q}, 33'h100000000);
	endtask
	task t_launch;
		cmd(8'h41);
		wfor(2, 0, w);
		chk(w, BYTE_CYC);
		cmd(8'h05);
		wfor(3, 0, w);
		chk(w >= CMD_CYC, 1'b1);
		chk({f_addr, phrase_launch_cmd_n[1], ready[1]}, 14'h0014);
		wfor(2, 0, w);
		chk({phrase_launch_cmd_n, ready}, 8'hDF);
		wfor(0, 1, w);
		chk(w >= 32, 1'b1);
		launch(8'h30, 8'h08);
		cmd(8'h51);
		wfor(3, 0, w);
		chk(f_addr, 12'h008);
		wfor(0, 0, w);
	endtask
	task t_chain;
		dly <= 5;
		r = nr0;
		fb = nf;
		launch(8'h44, 8'h00);
		launch(8'h44, 8'h01);
		wfor(2, 0, w);
		chk(ready[0], 1'b0);
		wfor(1, 0, w);
		chk(phrase_launch_cmd_n[0], 1'b0);
		wfor(0, 0, w);
		chk({nr0 - r, nf - fb}, {32'd1, 32'd2});
	endtask
	task t_silence;
		launch(8'h46, 8'h00);
		launch(8'h74, 8'h0F);
		wfor(2, 0, w);
		chk(ready[2], 1'b0);
		wfor(1, 2, w);
		chk(phrase_launch_cmd_n[2], 1'b0);
		launch(8'h46, 8'h01);
		wfor(2, 0, w);
		chk(ready[2], 1'b0);
		wfor(1, 2, w);
		chk(phrase_launch_cmd_n[2], 1'b0);
		wfor(0, 2, w);
	endtask
	task t_wide;
		cmd(8'hC8);
		cmd(8'h20);
		wfor(2, 0, w);
		chk(w, BYTE_CYC);
		cmd(8'h12);
		wfor(3, 0, w);
		chk(w >= CMD_CYC, 1'b1);
		chk({f_addr, phrase_launch_cmd_n[2]}, 13'h0024);
		wfor(0, 2, w);
	endtask
	task t_repeat;
		cmd(8'h88);
		wfor(2, 0, w);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(q[15], 1'b0);
		launch(8'h4F, 8'hFF);
		cmd(8'h88);
		wfor(2, 0, w);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({q[15], q[3]}, 2'b10);
		fb = nf;
		launch(8'h4F, 8'h01);
		wfor(2, 0, w);
		chk(nf - fb, 0);
		cmd(8'h98);
		wfor(2, 0, w);
		chk(ready[3], 1'b1);
		cmd(8'h68);
		wfor(0, 3, t_imm);
	endtask
	task t_gain_fade;
		launch(8'h08, 8'h3C);
		wfor(2, 0, w);
		chk(gain, 4'hF);
		launch(8'h06, 8'h00);
		wfor(2, 0, w);
		apb(1'b0, OFS_CFG, 32'h0);
		chk({gain, q}, {GAIN_0DB, 32'h1F});
		launch(8'h04, 8'h80);
		wfor(2, 0, w);
		chk(gain, 4'hF);
		launch(8'h4D, 8'hFF);
		cmd(8'h62);
		wfor(0, 1, w);
		// two samples of slack for pin sync jitter
		chk(w >= t_imm + (FADE_TICKS - 2) * 8, 1'b1);
	endtask
	task complete_run;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_regs;
		t_launch;
		t_chain;
		t_silence;
		t_wide;
		t_repeat;
		t_gain_fade;
		complete_run;
	end
	initial begin
		#9000000;
		errors++;
		complete_run;
	end
endmodule // tb
